// ===== hdl/iepr_top.sv
// interrupt enable, priority and request logic for the core
// assumes register accesses and pending flags come from core-clock logic
`timescale 1ns/100ps

// Behaviour
// RL1: enable bit 7 gates all sources
// RL2: gate at 0 blocks every request
// RL3: gate at 1 obeys each own mask
// RL4: enable bit 6 masks serial peripheral source
// RL5: enable bit 5 masks timer 2, either flag
// RL6: enable bit 4 masks asynchronous serial port
// RL7: enable bit 3 masks timer 1 overflow
// RL8: enable bit 2 masks external request one
// RL9: enable bit 1 masks timer 0 overflow
// RL10: enable bit 0 masks external request zero
// RL11: priority bit 7 reads 1, never changes
// RL12: priority bit 6 sets serial peripheral level
// RL13: priority bit 5 sets timer 2 level
// RL14: priority bit 4 sets serial port level
// RL15: priority bit 3 sets timer 1 level
// RL16: priority bit 2 sets external one level
// RL17: priority bit 1 sets timer 0 level
// RL18: priority bit 0 sets external zero level
// RL19: priority register at 0xB8, bit access
// RL20: extended enable: eight masks, reset zero
// RL21: extended bit 7 masks timer 3 flags
// RL22: high preempts low; fixed order breaks ties
// RL23: reset clears masks and levels
module iepr_top (
	input  logic                clk,
	input  logic                rst_n,
	input  logic [7:0]          sfrAddr,
	input  logic                sfrWrite,
	input  logic [7:0]          sfrWrData,
	input  logic                sfrRead,
	output logic [7:0]          sfrRdData,
	input  logic [7:0]          bitAddr,
	input  logic                bitWrite,
	input  logic                bitWrData,
	input  logic                bitRead,
	output logic                bitRdData,
	input  logic                externalRequestZero,
	input  logic                timer0Overflow,
	input  logic                externalRequestOne,
	input  logic                timer1Overflow,
	input  logic                uartPending,
	input  logic                timer2LowOverflow,
	input  logic                timer2HighOverflow,
	input  logic                spiPending,
	input  logic                smbusPending,
	input  logic                clockAlarmPending,
	input  logic                adcWindowPending,
	input  logic                adcDonePending,
	input  logic                counterArrayPending,
	input  logic                dmaMidPending,
	input  logic                dmaEndPending,
	input  logic                timer3LowOverflow,
	input  logic                timer3HighOverflow,
	input  logic                irqAck,
	input  logic                irqReturn,
	output logic                irqRequest,
	output logic                irqHigh,
	output iepr_pkg::iepr_src_t irqSource
);
	import iepr_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0]           enableMain_reg;
	logic [7:0]           priorityMain_reg;
	logic [7:0]           enableExt_reg;
	logic [7:0]           sfrRdData_reg;
	logic [7:0]           sfrRdData_next;
	logic                 bitRdData_reg;
	iepr_svc_t            svcState_reg;
	logic                 irqRequest_reg;
	logic                 irqRequest_next;
	logic                 irqHigh_reg;
	iepr_src_t            irqSource_reg;

	logic                 hitEnableMain;
	logic                 hitPriorityMain;
	logic                 hitEnableExt;
	logic                 bitHitPriority;
	logic [2:0]           bitIndex;
	logic [NUM_SRC-1:0]   sourceMask;
	logic [NUM_SRC-1:0]   sourceLevel;
	logic [NUM_SRC-1:0]   sourcePending;
	logic [NUM_SRC-1:0]   sourceActive;
	logic                 allowHigh;
	logic                 allowLow;
	logic                 winFound;
	logic                 winHigh;
	iepr_src_t            winSource;

	// ****************************************
	// address decode
	// ****************************************
	// register paging is ignored: all three registers answer on every page
	assign hitEnableMain   = (sfrAddr == ADDR_ENABLE_MAIN);
	assign hitPriorityMain = (sfrAddr == ADDR_PRIORITY_MAIN); // RL19
	assign hitEnableExt    = (sfrAddr == ADDR_ENABLE_EXT);
	assign bitHitPriority  = (bitAddr[7:3] == ADDR_PRIORITY_MAIN[7:3]); // RL19
	assign bitIndex        = bitAddr[2:0];

	// ****************************************
	// main enable register
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enableMain_reg <= ENABLE_MAIN_RESET; // RL23
		end else if (sfrWrite && hitEnableMain) begin
			enableMain_reg <= sfrWrData;
		end
	end

	// ****************************************
	// main priority register
	// ****************************************
	// byte write wins over a bit write landing in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			priorityMain_reg <= PRIORITY_MAIN_RESET; // RL23
		end else if (sfrWrite && hitPriorityMain) begin
			priorityMain_reg <= {1'b1, sfrWrData[PRIO_RESERVED_BIT-1:0]}; // RL11
		end else if (bitWrite && bitHitPriority && bitIndex != 3'h7) begin
			priorityMain_reg[bitIndex] <= bitWrData; // RL19
		end
	end

	// ****************************************
	// extended enable register
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enableExt_reg <= ENABLE_EXT_RESET; // RL20
		end else if (sfrWrite && hitEnableExt) begin
			enableExt_reg <= sfrWrData; // RL20
		end
	end

	// ****************************************
	// read paths
	// ****************************************
	always_comb begin
		sfrRdData_next = 8'h00;
		if (hitEnableMain) begin
			sfrRdData_next = enableMain_reg;
		end else if (hitPriorityMain) begin
			sfrRdData_next = priorityMain_reg;
		end else if (hitEnableExt) begin
			sfrRdData_next = enableExt_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sfrRdData_reg <= 8'h00;
		end else if (sfrRead) begin
			sfrRdData_reg <= sfrRdData_next;
		end
	end

	// unmapped bit addresses read as zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bitRdData_reg <= 1'b0;
		end else if (bitRead) begin
			bitRdData_reg <= bitHitPriority & priorityMain_reg[bitIndex]; // RL19
		end
	end

	assign sfrRdData = sfrRdData_reg;
	assign bitRdData = bitRdData_reg;

	// ****************************************
	// source vectors
	// ****************************************
	// source order matches the bit order of both enable registers
	assign sourceMask = {enableExt_reg, enableMain_reg[SRC_MAIN_COUNT-1:0]}; // RL4
	// extended sources have no level register here, so they stay low
	assign sourceLevel = {8'h00, priorityMain_reg[SRC_MAIN_COUNT-1:0]}; // RL12

	assign sourcePending = {
		timer3LowOverflow | timer3HighOverflow, // RL21
		dmaEndPending,
		dmaMidPending,
		counterArrayPending,
		adcDonePending,
		adcWindowPending,
		clockAlarmPending,
		smbusPending,
		spiPending, // RL4
		timer2LowOverflow | timer2HighOverflow, // RL5
		uartPending, // RL6
		timer1Overflow, // RL7
		externalRequestOne, // RL8
		timer0Overflow, // RL9
		externalRequestZero // RL10
	};

	iepr_gate u_gate (
		.globalGate    (enableMain_reg[GLOBAL_GATE_BIT]), // RL1
		.sourceMask    (sourceMask),
		.sourcePending (sourcePending),
		.sourceActive  (sourceActive)
	);

	// ****************************************
	// arbitration against level in service
	// ****************************************
	// a high routine blocks everything; a low one lets only high through
	assign allowHigh = (svcState_reg == SVC_NONE) || (svcState_reg == SVC_LOW); // RL22
	assign allowLow  = (svcState_reg == SVC_NONE); // RL22

	iepr_arbiter u_arbiter (
		.sourceActive (sourceActive),
		.sourceLevel  (sourceLevel),
		.allowHigh    (allowHigh),
		.allowLow     (allowLow),
		.winFound     (winFound),
		.winHigh      (winHigh),
		.winSource    (winSource)
	);

	// held off in the ack cycle so the taken source is not offered twice
	assign irqRequest_next = winFound & ~irqAck;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqRequest_reg <= 1'b0;
			irqHigh_reg    <= 1'b0;
			irqSource_reg  <= SRC_EXT0;
		end else begin
			irqRequest_reg <= irqRequest_next; // RL3
			irqHigh_reg    <= winHigh & irqRequest_next; // RL22
			irqSource_reg  <= winSource;
		end
	end

	assign irqRequest = irqRequest_reg;
	assign irqHigh    = irqHigh_reg;
	assign irqSource  = irqSource_reg;

	// ****************************************
	// service level tracking
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			svcState_reg <= SVC_NONE;
		end else begin
			case (svcState_reg)
				SVC_NONE: begin
					if (irqAck && irqRequest_reg) begin
						svcState_reg <= irqHigh_reg ? SVC_HIGH : SVC_LOW;
					end
				end
				SVC_LOW: begin
					if (irqAck && irqRequest_reg && irqHigh_reg) begin
						svcState_reg <= SVC_BOTH; // RL22
					end else if (irqReturn) begin
						svcState_reg <= SVC_NONE;
					end
				end
				SVC_HIGH: begin
					if (irqReturn) begin
						svcState_reg <= SVC_NONE;
					end
				end
				SVC_BOTH: begin
					if (irqReturn) begin
						svcState_reg <= SVC_LOW;
					end
				end
				default: begin
					svcState_reg <= SVC_NONE;
				end
			endcase
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_gate_closed;
		!enableMain_reg[GLOBAL_GATE_BIT] |=> !irqRequest;
	endproperty
	a_gate_closed: assert property (p_gate_closed) // RL2
		else $error("request raised while global gate closed");

	property p_ext0_passes;
		enableMain_reg[GLOBAL_GATE_BIT] && enableMain_reg[0] && externalRequestZero
		&& svcState_reg == SVC_NONE && !irqAck && (priorityMain_reg[0] || !winHigh)
		|=> irqRequest && irqSource == SRC_EXT0;
	endproperty
	a_ext0_passes: assert property (p_ext0_passes) // RL10
		else $error("enabled external request zero not offered");

	property p_spi_masked;
		irqRequest && irqSource == SRC_SPI |-> $past(enableMain_reg[6]);
	endproperty
	a_spi_masked: assert property (p_spi_masked) // RL4
		else $error("serial peripheral request passed its mask");

	property p_timer2_either;
		enableMain_reg[7] && enableMain_reg[5] && sourcePending[14:6] == 9'h000 && !irqAck
		&& timer2HighOverflow && !timer2LowOverflow && sourcePending[4:0] == 5'h00 && allowLow
		|=> irqRequest && irqSource == SRC_TIMER2;
	endproperty
	a_timer2_either: assert property (p_timer2_either) // RL5
		else $error("timer 2 high flag did not raise a request");

	property p_uart_masked;
		irqRequest && irqSource == SRC_UART |-> $past(enableMain_reg[4]);
	endproperty
	a_uart_masked: assert property (p_uart_masked) // RL6
		else $error("serial port request passed its mask");

	property p_timer1_masked;
		irqRequest && irqSource == SRC_TIMER1 |-> $past(enableMain_reg[3]);
	endproperty
	a_timer1_masked: assert property (p_timer1_masked) // RL7
		else $error("timer 1 request passed its mask");

	property p_timer3_masked;
		irqRequest && irqSource == SRC_TIMER3 |-> $past(enableExt_reg[7]);
	endproperty
	a_timer3_masked: assert property (p_timer3_masked) // RL21
		else $error("timer 3 request passed its mask");

	property p_level_follows;
		irqRequest && irqSource == SRC_UART |-> irqHigh == $past(priorityMain_reg[4]);
	endproperty
	a_level_follows: assert property (p_level_follows) // RL14
		else $error("serial port level differs from priority bit");

	property p_reserved_reads_one;
		sfrRead && hitPriorityMain |=> sfrRdData[PRIO_RESERVED_BIT];
	endproperty
	a_reserved_reads_one: assert property (p_reserved_reads_one) // RL11
		else $error("reserved priority bit read as zero");

	property p_bit_write;
		bitWrite && !sfrWrite && bitAddr == 8'hba
		|=> priorityMain_reg[2] == $past(bitWrData);
	endproperty
	a_bit_write: assert property (p_bit_write) // RL19
		else $error("single-bit write to priority bit 2 lost");

	property p_ext_write;
		sfrWrite && hitEnableExt |=> enableExt_reg == $past(sfrWrData);
	endproperty
	a_ext_write: assert property (p_ext_write) // RL20
		else $error("extended enable write not stored");

	property p_low_blocks_low;
		svcState_reg == SVC_LOW |=> !irqRequest || irqHigh;
	endproperty
	a_low_blocks_low: assert property (p_low_blocks_low) // RL22
		else $error("low request offered during low service");

	sequence s_take_high;
		irqAck && irqRequest && irqHigh && svcState_reg == SVC_LOW;
	endsequence
	sequence s_nested;
		svcState_reg == SVC_BOTH ##1 !irqRequest;
	endsequence
	property p_preempt;
		s_take_high |=> s_nested;
	endproperty
	a_preempt: assert property (p_preempt) // RL22
		else $error("high preemption not tracked or not blocking");

endmodule

// ===== hdl/iepr_pkg.sv
// constants and types shared by the interrupt enable and priority block
// assumes an 8-bit special-function register space on the core clock
package iepr_pkg;

	// ****************************************
	// register addresses and layout
	// ****************************************
	localparam logic [7:0] ADDR_ENABLE_MAIN   = 8'ha8;
	localparam logic [7:0] ADDR_PRIORITY_MAIN = 8'hb8;
	localparam logic [7:0] ADDR_ENABLE_EXT    = 8'he6;

	localparam int unsigned GLOBAL_GATE_BIT   = 7;
	localparam int unsigned PRIO_RESERVED_BIT = 7;
	localparam int unsigned SRC_MAIN_COUNT    = 7;
	localparam int unsigned NUM_SRC           = 15;

	// ****************************************
	// values after reset
	// ****************************************
	localparam logic [7:0] ENABLE_MAIN_RESET   = 8'h00;
	localparam logic [7:0] PRIORITY_MAIN_RESET = 8'h80;
	localparam logic [7:0] ENABLE_EXT_RESET    = 8'h00;

	// ****************************************
	// sources in fixed service order
	// ****************************************
	typedef enum logic [3:0] {
		SRC_EXT0      = 4'h0,
		SRC_TIMER0    = 4'h1,
		SRC_EXT1      = 4'h2,
		SRC_TIMER1    = 4'h3,
		SRC_UART      = 4'h4,
		SRC_TIMER2    = 4'h5,
		SRC_SPI       = 4'h6,
		SRC_SMBUS     = 4'h7,
		SRC_ALARM     = 4'h8,
		SRC_ADC_WIN   = 4'h9,
		SRC_ADC_DONE  = 4'ha,
		SRC_COUNTER   = 4'hb,
		SRC_DMA_MID   = 4'hc,
		SRC_DMA_END   = 4'hd,
		SRC_TIMER3    = 4'he
	} iepr_src_t;

	// levels of service currently under way in the core
	typedef enum logic [1:0] {
		SVC_NONE = 2'b00,
		SVC_LOW  = 2'b01,
		SVC_HIGH = 2'b10,
		SVC_BOTH = 2'b11
	} iepr_svc_t;

endpackage

// ===== hdl/iepr_gate.sv
// per-source gating of pending flags by the global gate and source masks
// assumes flags and masks are on the same clock as the caller
`timescale 1ns/100ps
module iepr_gate (
	input  logic                         globalGate,
	input  logic [iepr_pkg::NUM_SRC-1:0] sourceMask,
	input  logic [iepr_pkg::NUM_SRC-1:0] sourcePending,
	output logic [iepr_pkg::NUM_SRC-1:0] sourceActive
);
	import iepr_pkg::*;

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : gen_src
			// the global gate overrides every individual mask
			assign sourceActive[g] = globalGate & sourceMask[g] & sourcePending[g]; // RL2 RL3
		end
	endgenerate

endmodule

// ===== hdl/iepr_arbiter.sv
// picks the winning source: high level first, then lowest source number
// assumes active and level vectors are stable for the cycle
`timescale 1ns/100ps
module iepr_arbiter (
	input  logic [iepr_pkg::NUM_SRC-1:0] sourceActive,
	input  logic [iepr_pkg::NUM_SRC-1:0] sourceLevel,
	input  logic                         allowHigh,
	input  logic                         allowLow,
	output logic                         winFound,
	output logic                         winHigh,
	output iepr_pkg::iepr_src_t          winSource
);
	import iepr_pkg::*;

	logic       hiFound;
	logic [3:0] hiIdx;
	logic       anyFound;
	logic [3:0] anyIdx;

	always_comb begin
		hiFound  = 1'b0;
		hiIdx    = 4'h0;
		anyFound = 1'b0;
		anyIdx   = 4'h0;
		// walk downward so the lowest source number is the last to land
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (sourceActive[i]) begin
				anyFound = 1'b1;
				anyIdx   = 4'(i);
				if (sourceLevel[i]) begin // RL12 RL13 RL14 RL15 RL16 RL17 RL18
					hiFound = 1'b1;
					hiIdx   = 4'(i);
				end
			end
		end
		winHigh   = hiFound & allowHigh;
		winFound  = winHigh | (anyFound & allowLow);
		winSource = iepr_src_t'(winHigh ? hiIdx : anyIdx);
	end

endmodule

// ===== bench/iepr_core_model.sv
// behavioural core: takes offered requests and retires them on command
// assumes the block's request outputs are on the same clock
`timescale 1ns/100ps
module iepr_core_model (
	input  logic                clk,
	input  logic                rst_n,
	input  logic                irqRequest,
	input  logic                irqHigh,
	input  iepr_pkg::iepr_src_t irqSource,
	input  logic                autoAck,
	input  logic [3:0]          ackDelay,
	input  logic                retire,
	output logic                irqAck,
	output logic                irqReturn,
	output iepr_pkg::iepr_src_t takenSource,
	output logic                takenHigh,
	output logic [7:0]          takenCount
);
	import iepr_pkg::*;

	logic [3:0] waitCnt;

	// ****************************************
	// acceptance and retirement
	// ****************************************
	// ack only while the offer stands; slow mode lets it stand ackDelay cycles first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqAck <= 1'b0;
			waitCnt <= 4'h0;
			takenSource <= SRC_EXT0;
			takenHigh <= 1'b0;
			takenCount <= 8'h00;
		end else if (irqAck) begin
			irqAck <= 1'b0;
			waitCnt <= 4'h0;
		end else if (irqRequest && autoAck) begin
			if (waitCnt >= ackDelay) begin
				irqAck <= 1'b1;
				takenSource <= irqSource;
				takenHigh <= irqHigh;
				takenCount <= takenCount + 8'h01;
			end else begin
				waitCnt <= waitCnt + 4'h1;
			end
		end else begin
			waitCnt <= 4'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqReturn <= 1'b0;
		end else begin
			irqReturn <= retire && !irqReturn;
		end
	end
endmodule

// ===== bench/tb.sv
// self-checking bench for the interrupt enable and priority block
// assumes the core model file is compiled before this one
`timescale 1ns/100ps
module tb;
	import iepr_pkg::*;

	logic clk = 1'b0, rst_n = 1'b0;
	logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, bitAddr = 8'h00, sfrRdData, rd;
	logic sfrWrite = 1'b0, sfrRead = 1'b0, bitWrite = 1'b0, bitWrData = 1'b0, bitRead = 1'b0;
	logic bitRdData, irqAck, irqReturn, irqRequest, irqHigh, takenHigh, bv;
	logic autoAck = 1'b0, retire = 1'b0;
	logic [3:0] ackDelay = 4'h0;
	logic [16:0] flags = 17'h00000;
	logic [7:0] ieS, ipS, eieS, takenCount, acc;
	iepr_src_t irqSource, takenSource;
	int fails = 0, cmpCount = 0;
	int unsigned seedVal;

	always #2 clk = ~clk;

	iepr_top i_iepr_top (.clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
		.sfrWrData(sfrWrData), .sfrRead(sfrRead), .sfrRdData(sfrRdData), .bitAddr(bitAddr),
		.bitWrite(bitWrite), .bitWrData(bitWrData), .bitRead(bitRead), .bitRdData(bitRdData),
		.externalRequestZero(flags[0]), .timer0Overflow(flags[1]),
		.externalRequestOne(flags[2]), .timer1Overflow(flags[3]), .uartPending(flags[4]),
		.timer2LowOverflow(flags[5]), .timer2HighOverflow(flags[6]), .spiPending(flags[7]),
		.smbusPending(flags[8]), .clockAlarmPending(flags[9]), .adcWindowPending(flags[10]),
		.adcDonePending(flags[11]), .counterArrayPending(flags[12]),
		.dmaMidPending(flags[13]), .dmaEndPending(flags[14]),
		.timer3LowOverflow(flags[15]), .timer3HighOverflow(flags[16]), .irqAck(irqAck),
		.irqReturn(irqReturn), .irqRequest(irqRequest), .irqHigh(irqHigh),
		.irqSource(irqSource));

	iepr_core_model i_iepr_core_model (.clk(clk), .rst_n(rst_n), .irqRequest(irqRequest),
		.irqHigh(irqHigh), .irqSource(irqSource), .autoAck(autoAck), .ackDelay(ackDelay),
		.retire(retire), .irqAck(irqAck), .irqReturn(irqReturn),
		.takenSource(takenSource), .takenHigh(takenHigh), .takenCount(takenCount));

	// ****************************************
	// expectations and reporting
	// ****************************************
	// timer 2 and timer 3 each merge two overflow flags into one source
	function automatic logic [14:0] pendOf(input logic [16:0] f);
		pendOf = {f[16] | f[15], f[14:8], f[7], f[6] | f[5], f[4:0]};
	endfunction

	// svc: 0 idle, 1 low routine running, 2 high routine running
	function automatic logic [5:0] expOf(input logic [16:0] f, input logic [1:0] svc);
		logic [14:0] act;
		act = {eieS, ieS[6:0]} & pendOf(f) & {15{ieS[7]}};
		expOf = 6'h00;
		for (int i = 14; i >= 0; i--) begin
			if (act[i] && (i > 6 || !ipS[i]) && svc == 2'd0) expOf = {2'b10, 4'(i)};
		end
		for (int i = 6; i >= 0; i--) begin
			if (act[i] && ipS[i] && svc != 2'd2) expOf = {2'b11, 4'(i)};
		end
	endfunction

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmpCount++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", cmpCount, fails);
		if (fails == 0 && cmpCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// register and request drivers
	// ****************************************
	task automatic sfrWr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrite <= 1'b1;
		@(posedge clk);
		sfrWrite <= 1'b0;
	endtask

	task automatic regCheck(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		sfrAddr <= a;
		sfrRead <= 1'b1;
		@(posedge clk);
		sfrRead <= 1'b0;
		@(negedge clk);
		check(what, exp, sfrRdData);
	endtask

	task automatic bitOp(input logic [7:0] a, input logic wr, input logic v);
		@(posedge clk);
		bitAddr <= a;
		bitWrData <= v;
		bitWrite <= wr;
		bitRead <= !wr;
		@(posedge clk);
		bitWrite <= 1'b0;
		bitRead <= 1'b0;
		@(negedge clk);
		bv = bitRdData;
	endtask

	task automatic setRegs(input logic [7:0] e, input logic [7:0] p, input logic [7:0] x);
		ieS = e;
		ipS = p | 8'h80;
		eieS = x;
		sfrWr(ADDR_ENABLE_MAIN, ieS);
		sfrWr(ADDR_PRIORITY_MAIN, ipS);
		sfrWr(ADDR_ENABLE_EXT, eieS);
	endtask

	// flag driven at the next edge, offer registered at the edge after
	task automatic flagCheck(input logic [16:0] f, input logic [1:0] svc, input string what);
		logic [5:0] e;
		@(posedge clk);
		flags <= f;
		repeat (2) @(posedge clk);
		@(negedge clk);
		e = expOf(f, svc);
		check(what, {2'b00, e}, {2'b00, irqRequest, irqRequest ? {irqHigh, irqSource} : 5'h00});
	endtask

	task automatic takeOne(input logic [7:0] n, input logic [5:0] exp);
		autoAck <= 1'b1;
		ackDelay <= 4'($urandom_range(3, 0));
		for (int i = 0; i < 30 && takenCount != n; i++) @(posedge clk);
		if (takenCount != n) begin
			fails++;
			endOfTest();
		end else begin
			autoAck <= 1'b0;
			check("taken", {3'b001, exp[4:0]}, {3'b001, takenHigh, takenSource});
		end
	endtask

	task automatic retireOne();
		@(posedge clk);
		retire <= 1'b1;
		@(posedge clk);
		retire <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		seedVal = $urandom(82);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		regCheck(ADDR_ENABLE_MAIN, 8'h00, "enable main reset");
		regCheck(ADDR_PRIORITY_MAIN, 8'h80, "priority reset");
		regCheck(ADDR_ENABLE_EXT, 8'h00, "extended reset");
		regCheck(8'h55, 8'h00, "unmapped read");
		sfrWr(ADDR_PRIORITY_MAIN, 8'h00);
		regCheck(ADDR_PRIORITY_MAIN, 8'h80, "reserved bit byte write");
		bitOp(ADDR_PRIORITY_MAIN + 8'h07, 1'b1, 1'b0);
		bitOp(ADDR_PRIORITY_MAIN + 8'h07, 1'b0, 1'b0);
		check("reserved bit bit write", 8'h01, {7'h00, bv});
		acc = 8'h80;
		for (int i = 0; i < 7; i++) begin
			acc[i] = 1'($urandom);
			bitOp(ADDR_PRIORITY_MAIN + 8'(i), 1'b1, acc[i]);
			bitOp(ADDR_PRIORITY_MAIN + 8'(i), 1'b0, 1'b0);
			check("priority bit", {7'h00, acc[i]}, {7'h00, bv});
		end
		regCheck(ADDR_PRIORITY_MAIN, acc, "priority after bit writes");
		acc = 8'($urandom);
		sfrWr(ADDR_ENABLE_EXT, acc);
		regCheck(ADDR_ENABLE_EXT, acc, "extended read back");
		for (int k = 0; k < 17; k++) begin
			setRegs(8'hff, 8'($urandom), 8'hff);
			flagCheck(17'(1 << k), 2'd0, "single flag");
			setRegs(8'h7f, ipS, 8'hff);
			flagCheck(17'h1ffff, 2'd0, "gate closed");
		end
		for (int t = 0; t < 60; t++) begin
			setRegs(8'($urandom), 8'($urandom), 8'($urandom));
			flagCheck(17'($urandom) & 17'($urandom), 2'd0, "random offer");
		end
		setRegs(8'hc5, 8'h40, 8'h00);
		flagCheck(17'h00001, 2'd0, "low offer");
		takeOne(8'h01, 6'h00);
		flagCheck(17'h00005, 2'd1, "low blocked in low service");
		flagCheck(17'h00085, 2'd1, "high preempts");
		takeOne(8'h02, 6'h16);
		flagCheck(17'h00085, 2'd2, "nothing in high service");
		flagCheck(17'h00005, 2'd2, "still high service");
		retireOne();
		flagCheck(17'h00005, 2'd1, "back to low service");
		retireOne();
		flagCheck(17'h00005, 2'd0, "idle again, order");
		endOfTest();
	end
endmodule
